// ### msd_pkg.sv
package msd_pkg;

    // register offsets on the apb bus (byte addresses)
    localparam logic [7:0] MSD_OFF_MICRO = 8'h00;
    localparam logic [7:0] MSD_OFF_FLAGS = 8'h04;
    localparam logic [7:0] MSD_OFF_REG_SEL = 8'h08;
    localparam logic [7:0] MSD_OFF_REG_DATA = 8'h0C;
    localparam logic [7:0] MSD_OFF_STATUS = 8'h10;

    // microinstruction fields
    localparam int MSD_B_MSB = 7;
    localparam int MSD_B_LSB = 4;
    localparam int MSD_A_MSB = 3;
    localparam int MSD_A_LSB = 0;
    localparam int MSD_FLAGGED_BIT = 8;
    localparam int MSD_WORD_BIT = 9;
    localparam int MSD_ZERO_BIT = 10;
    localparam int MSD_BORROW_BIT = 11;
    localparam logic [3:0] MSD_GROUP = 4'hB;

    // flags register layout
    localparam int MSD_FL_C = 0;
    localparam int MSD_FL_V = 1;
    localparam int MSD_FL_Z = 2;
    localparam int MSD_FL_N = 3;
    localparam int MSD_FL_HIGH_CARRY = 4;
    localparam int MSD_FL_LOW_DIGIT_CARRY = 5;
    localparam int MSD_FL_BYTE_ZERO = 6;
    localparam int MSD_FL_BYTE_NEGATIVE = 7;

    // status register layout
    localparam int MSD_ST_BUSY = 0;
    localparam int MSD_ST_ILLEGAL = 1;

    localparam logic [15:0] MSD_MICRO_RESET = 16'h0000;
    localparam logic [7:0] MSD_FLAGS_RESET = 8'h00;
    localparam logic [3:0] MSD_SEL_RESET = 4'h0;

    typedef enum logic [1:0]
    {
        MSD_IDLE = 2'b00,
        MSD_FETCH = 2'b01,
        MSD_EXEC = 2'b11
    } msd_state_t;

endpackage

// ### msd_rf_if.sv
`timescale 1ns/1ps

interface msd_rf_if;
    logic [3:0] addr_a;
    logic [3:0] addr_b;
    logic [15:0] rdata_a;
    logic [15:0] rdata_b;
    logic [3:0] waddr;
    logic [15:0] wdata;
    logic we_lo;
    logic we_hi;

    modport ctrl
    (
        output addr_a,
        output addr_b,
        input rdata_a,
        input rdata_b,
        output waddr,
        output wdata,
        output we_lo,
        output we_hi
    );

    modport mem
    (
        input addr_a,
        input addr_b,
        output rdata_a,
        output rdata_b,
        input waddr,
        input wdata,
        input we_lo,
        input we_hi
    );
endinterface

// ### msd_regfile.sv
`timescale 1ns/1ps

module msd_regfile
(
    input wire logic pclk,
    input wire logic presetn,
    msd_rf_if.mem rf
);

    logic [7:0] mem [0:15];

    // a pair is the addressed register and the next higher one, wrapping at 15
    wire [3:0] next_a = rf.addr_a + 4'h1;
    wire [3:0] next_b = rf.addr_b + 4'h1;
    wire [3:0] next_w = rf.waddr + 4'h1;

    always_ff @(posedge pclk)
    begin
        if (rf.we_lo)
            mem[rf.waddr] <= rf.wdata[7:0];
        if (rf.we_hi)
            mem[next_w] <= rf.wdata[15:8];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rf.rdata_a <= 16'h0000;
            rf.rdata_b <= 16'h0000;
        end
        else
        begin
            rf.rdata_a <= {mem[next_a], mem[rf.addr_a]};
            rf.rdata_b <= {mem[next_b], mem[rf.addr_b]};
        end
    end

endmodule

// ### msd_datapath.sv
`timescale 1ns/1ps

// Operation
// RULE1 - byte subtract: a_register minus b_register into a_register; bit 8 selects flagged form
// RULE2 - byte subtract with borrow: a minus b minus C, 8 bits, into a_register
// RULE3 - word subtract, even B: A pair minus B pair into A pair; B pair untouched
// RULE4 - word subtract, odd B: single b_register sign-extended through 8 upper bits
// RULE5 - word subtract with borrow: A pair minus B pair minus C, 16 bits
// RULE6 - word subtract with borrow, odd B: widened b_register minus C; B pair untouched
// RULE7 - every subtract updates byte_negative, byte_zero, low_digit_carry, high_carry
// RULE8 - byte forms: byte_negative on negative 8-bit result, byte_zero on zero
// RULE9 - word forms: byte_negative on negative 16-bit result, byte_zero on zero
// RULE10 - low_digit_carry is the carry out of bit 3
// RULE11 - high_carry is the carry out of the most significant position
// RULE12 - only flagged forms update N Z V C; plain forms keep them
// RULE13 - flagged forms: N on negative result, Z on zero result
// RULE14 - flagged forms: V on two's-complement overflow
// RULE15 - flagged forms: C set on borrow, cleared otherwise
// RULE16 - B field is bits 7..4, A field bits 3..0; pair is register and next
// RULE17 - high_carry comes from one adder: a plus not b plus inverted borrow-in; low_digit_carry comes from a second nibble adder
module msd_datapath
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    ////////////////////////////////////////////////////////////////////////////

    // a + b + cin on 16 bits, carry out in bit 16
    function automatic logic [16:0] msd_add(input logic [15:0] a, input logic [15:0] b, input logic cin);
        msd_add = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    endfunction

    // two's-complement overflow of a subtract: operand signs differ, result sign differs from a
    function automatic logic msd_ovf(input logic a_msb, input logic b_msb, input logic r_msb);
        msd_ovf = (a_msb != b_msb) && (r_msb != a_msb);
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    msd_rf_if rf ();

    msd_regfile u_regfile
    (
        .pclk(pclk),
        .presetn(presetn),
        .rf(rf.mem)
    );

    msd_pkg::msd_state_t state;
    msd_pkg::msd_state_t next_state;
    logic [15:0] micro;
    logic [7:0] flags;
    logic [3:0] reg_sel;
    logic illegal;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire access = psel && penable;
    wire idle = (state == msd_pkg::MSD_IDLE);
    wire hit_micro = (paddr == msd_pkg::MSD_OFF_MICRO);
    wire hit_flags = (paddr == msd_pkg::MSD_OFF_FLAGS);
    wire hit_sel = (paddr == msd_pkg::MSD_OFF_REG_SEL);
    wire hit_data = (paddr == msd_pkg::MSD_OFF_REG_DATA);
    wire hit_status = (paddr == msd_pkg::MSD_OFF_STATUS);
    wire mapped = hit_micro || hit_flags || hit_sel || hit_data || hit_status;

    // every access waits out a running microinstruction so software never
    // sees half-updated registers or flags
    assign pready = idle;
    assign pslverr = access && idle && !mapped;

    wire done = access && idle;
    wire wr_micro = done && pwrite && hit_micro;
    wire wr_flags = done && pwrite && hit_flags;
    wire wr_sel = done && pwrite && hit_sel;
    wire wr_data = done && pwrite && hit_data;

    ////////////////////////////////////////////////////////////////////////////
    // microinstruction decode

    wire [15:0] new_micro = pwdata[15:0];
    wire new_valid = (new_micro[15:12] == msd_pkg::MSD_GROUP) && !new_micro[msd_pkg::MSD_ZERO_BIT];

    wire [3:0] field_b = micro[msd_pkg::MSD_B_MSB:msd_pkg::MSD_B_LSB]; // RULE16
    wire [3:0] field_a = micro[msd_pkg::MSD_A_MSB:msd_pkg::MSD_A_LSB]; // RULE16
    wire op_word = micro[msd_pkg::MSD_WORD_BIT];
    wire op_borrow = micro[msd_pkg::MSD_BORROW_BIT];
    wire op_flagged = micro[msd_pkg::MSD_FLAGGED_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // register file addressing: the microinstruction while busy, the software
    // selector while idle so register data is ready to read

    assign rf.addr_a = idle ? reg_sel : field_a;
    assign rf.addr_b = idle ? reg_sel : field_b;

    wire [15:0] a_pair = rf.rdata_a;
    wire [15:0] b_pair = rf.rdata_b;

    // odd B on a word op uses one register widened by its sign
    wire [15:0] b_wide = {{8{b_pair[7]}}, b_pair[7:0]}; // RULE4 RULE6
    wire [15:0] b_word = field_b[0] ? b_wide : b_pair; // RULE3 RULE4
    wire [15:0] b_oper = op_word ? b_word : {8'h00, b_pair[7:0]};
    wire [15:0] a_oper = op_word ? a_pair : {8'h00, a_pair[7:0]};

    ////////////////////////////////////////////////////////////////////////////
    // two adders, word and low nibble: a + ~b + carry-in, carry-in is the inverted borrow

    wire carry_in = op_borrow ? !flags[msd_pkg::MSD_FL_C] : 1'b1; // RULE2 RULE5 RULE17
    wire [15:0] b_inv = op_word ? ~b_oper : {8'h00, ~b_oper[7:0]};
    wire [16:0] sum_word = msd_add(a_oper, b_inv, carry_in); // RULE17
    wire [16:0] sum_nib = msd_add({12'h000, a_oper[3:0]}, {12'h000, b_inv[3:0]}, carry_in); // RULE17

    wire [15:0] diff = op_word ? sum_word[15:0] : {8'h00, sum_word[7:0]}; // RULE1 RULE3 RULE5
    wire carry_top = op_word ? sum_word[16] : sum_word[8]; // RULE11
    wire carry_low = sum_nib[4]; // RULE10
    wire res_neg = op_word ? diff[15] : diff[7]; // RULE8 RULE9
    wire res_zero = op_word ? (diff == 16'h0000) : (diff[7:0] == 8'h00); // RULE8 RULE9
    wire a_msb = op_word ? a_oper[15] : a_oper[7];
    wire b_msb = op_word ? b_oper[15] : b_oper[7];
    wire res_ovf = msd_ovf(a_msb, b_msb, res_neg); // RULE14

    wire exec = (state == msd_pkg::MSD_EXEC);

    ////////////////////////////////////////////////////////////////////////////
    // register file writes: result into a_register (pair), software data byte

    // byte forms write a_register only; word forms write the a pair and never
    // the b pair
    assign rf.waddr = exec ? field_a : reg_sel;
    assign rf.wdata = exec ? diff : {8'h00, pwdata[7:0]};
    assign rf.we_lo = (exec) || wr_data; // RULE1 RULE2
    assign rf.we_hi = exec && op_word; // RULE3 RULE5 RULE6

    ////////////////////////////////////////////////////////////////////////////
    // flags update

    logic [7:0] next_flags;

    always_comb
    begin
        next_flags = flags;
        if (wr_flags)
            next_flags = pwdata[7:0];
        if (exec)
        begin
            next_flags[msd_pkg::MSD_FL_BYTE_NEGATIVE] = res_neg; // RULE7 RULE8 RULE9
            next_flags[msd_pkg::MSD_FL_BYTE_ZERO] = res_zero; // RULE7 RULE8 RULE9
            next_flags[msd_pkg::MSD_FL_LOW_DIGIT_CARRY] = carry_low; // RULE7 RULE10
            next_flags[msd_pkg::MSD_FL_HIGH_CARRY] = carry_top; // RULE7 RULE11
            if (op_flagged) // RULE12
            begin
                next_flags[msd_pkg::MSD_FL_N] = res_neg; // RULE13
                next_flags[msd_pkg::MSD_FL_Z] = res_zero; // RULE13
                next_flags[msd_pkg::MSD_FL_V] = res_ovf; // RULE14
                next_flags[msd_pkg::MSD_FL_C] = !carry_top; // RULE15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: fetch reads both pairs, exec writes result and flags

    always_comb
    begin
        case (state)
            msd_pkg::MSD_IDLE:
                next_state = (wr_micro && new_valid) ? msd_pkg::MSD_FETCH : msd_pkg::MSD_IDLE;
            msd_pkg::MSD_FETCH:
                next_state = msd_pkg::MSD_EXEC;
            msd_pkg::MSD_EXEC:
                next_state = msd_pkg::MSD_IDLE;
            default:
                next_state = msd_pkg::MSD_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= msd_pkg::MSD_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags <= msd_pkg::MSD_FLAGS_RESET;
        else
            flags <= next_flags;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            micro <= msd_pkg::MSD_MICRO_RESET;
        else if (wr_micro)
            micro <= new_micro;
    end

    // an unsupported opcode is not executed; the flag holds until the next microinstruction write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            illegal <= 1'b0;
        else if (wr_micro)
            illegal <= !new_valid;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reg_sel <= msd_pkg::MSD_SEL_RESET;
        else if (wr_sel)
            reg_sel <= pwdata[3:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered at the edge before the access edge

    logic [31:0] rd_mux;

    // the read view looks one edge ahead: prdata is latched at the edge before the
    // access edge, which for a read that waited out a microinstruction is the edge
    // at which the flags are written and the sequencer goes idle
    wire [7:0] flags_view = next_flags; // RULE7 RULE12
    wire busy_view = (next_state != msd_pkg::MSD_IDLE);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_micro)
            rd_mux = {16'h0000, micro};
        else if (hit_flags)
            rd_mux = {24'h00_0000, flags_view};
        else if (hit_sel)
            rd_mux = {28'h000_0000, reg_sel};
        else if (hit_data)
            rd_mux = {24'h00_0000, rf.rdata_a[7:0]};
        else if (hit_status)
            rd_mux = {30'h0000_0000, illegal, busy_view};
    end

    // prdata follows the read mux during setup so it is valid at the access edge
    // limitation: register data reaches the mux one cycle after the selector or an
    // execution changes it, so a data read needs an idle cycle after either
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !pwrite)
            prdata <= rd_mux;
    end

endmodule

// ### msd_datapath_assertions.sv
`timescale 1ns/1ps

module msd_datapath_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire acc = psel && penable && pready;
    wire mapped = (paddr == msd_pkg::MSD_OFF_MICRO) || (paddr == msd_pkg::MSD_OFF_FLAGS)
        || (paddr == msd_pkg::MSD_OFF_REG_SEL) || (paddr == msd_pkg::MSD_OFF_REG_DATA)
        || (paddr == msd_pkg::MSD_OFF_STATUS);
    // any subtract in the group has bit 10 clear; everything else is refused
    wire op_ok = (pwdata[15:12] == msd_pkg::MSD_GROUP) && !pwdata[msd_pkg::MSD_ZERO_BIT];
    wire micro_wr = acc && pwrite && (paddr == msd_pkg::MSD_OFF_MICRO);

    chk_busy_after_op: assert property (micro_wr && op_ok |=> !pready [*2] ##1 pready)
        else $error("bus not stalled two cycles after a subtract");
    chk_illegal_no_busy: assert property (micro_wr && !op_ok |=> pready)
        else $error("refused opcode stalled the bus");
    chk_busy_bounded: assert property ($fell(pready) |-> ##[1:2] pready)
        else $error("stall lasted too long");
    chk_err_unmapped: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    chk_err_mapped: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped access");
    chk_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access phase");
    chk_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_flags_width: assert property (acc && !pwrite && paddr == msd_pkg::MSD_OFF_FLAGS |-> prdata[31:8] == 24'h00_0000)
        else $error("flags upper bits set");
    chk_status_width: assert property (acc && !pwrite && paddr == msd_pkg::MSD_OFF_STATUS |-> prdata[31:2] == 30'h0000_0000)
        else $error("status upper bits set");
endmodule

bind msd_datapath msd_datapath_chk i_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// ### tb.sv
`timescale 1ns/1ps

module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic last_err;
    logic [31:0] rd;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    // op, flags, a, a+1, b, b+1; a and b pairs never overlap
    function automatic logic [55:0] tbl(input int i);
        case (i)
            0: tbl = 56'hB052_0F80_0001_00;
            1: tbl = 56'hB152_0080_0001_00;
            2: tbl = 56'hB862_0100_0000_00;
            3: tbl = 56'hB962_0110_000F_00;
            4: tbl = 56'hB262_0000_0001_00;
            5: tbl = 56'hB352_0000_0180_00;
            6: tbl = 56'hBA62_0134_1234_12;
            7: tbl = 56'hBB5F_0000_80FF_7F;
            default: tbl = 56'hB1E1_0E33_0033_00;
        endcase
    endfunction

    always #5 pclk = ~pclk;

    msd_datapath i_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // pready, prdata and pslverr are read just after the rising edge, before the
    // design's flip-flops update, so they hold the values the edge sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_reg(input logic [3:0] i, input logic [7:0] v);
        apb(1'b1, msd_pkg::MSD_OFF_REG_SEL, {28'h000_0000, i});
        apb(1'b1, msd_pkg::MSD_OFF_REG_DATA, {24'h00_0000, v});
    endtask

    task automatic get_reg(input logic [3:0] i);
        apb(1'b1, msd_pkg::MSD_OFF_REG_SEL, {28'h000_0000, i});
        apb(1'b0, msd_pkg::MSD_OFF_REG_DATA, 32'h0000_0000);
    endtask

    task automatic run_op(input logic [55:0] t);
        logic [15:0] op;
        logic [7:0] fl, ra, ra1, rb, rb1, ef;
        logic [15:0] x, y;
        logic [16:0] s;
        logic [4:0] lo;
        logic w, cin, cy, ng, zr, xm, ym;
        {op, fl, ra, ra1, rb, rb1} = t;
        w = op[msd_pkg::MSD_WORD_BIT];
        cin = op[msd_pkg::MSD_BORROW_BIT] ? ~fl[0] : 1'b1;
        x = w ? {ra1, ra} : {8'h00, ra};
        y = !w ? {8'h00, rb} : op[4] ? {{8{rb[7]}}, rb} : {rb1, rb};
        s = {1'b0, x} + {1'b0, w ? ~y : {8'h00, ~rb}} + 17'(cin);
        lo = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + 5'(cin);
        cy = w ? s[16] : s[8];
        ng = w ? s[15] : s[7];
        zr = w ? (s[15:0] == 16'h0000) : (s[7:0] == 8'h00);
        xm = w ? x[15] : x[7];
        ym = w ? y[15] : y[7];
        ef = {ng, zr, lo[4], cy, op[8] ? {ng, zr, (xm != ym) && (ng != xm), ~cy} : fl[3:0]};
        set_reg(op[7:4], rb);
        set_reg(op[7:4] + 4'd1, rb1);
        set_reg(op[3:0], ra);
        set_reg(op[3:0] + 4'd1, ra1);
        apb(1'b1, msd_pkg::MSD_OFF_FLAGS, {24'h00_0000, fl});
        apb(1'b1, msd_pkg::MSD_OFF_MICRO, {16'h0000, op});
        apb(1'b0, msd_pkg::MSD_OFF_FLAGS, 32'h0000_0000);
        check(rd, {24'h00_0000, ef});
        get_reg(op[3:0]);
        check(rd, {24'h00_0000, s[7:0]});
        get_reg(op[3:0] + 4'd1);
        check(rd, {24'h00_0000, w ? s[15:8] : ra1});
        get_reg(op[7:4]);
        check(rd, {24'h00_0000, rb});
        get_reg(op[7:4] + 4'd1);
        check(rd, {24'h00_0000, rb1});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, msd_pkg::MSD_OFF_MICRO, 32'h0000_0000);
        check(rd, {16'h0000, msd_pkg::MSD_MICRO_RESET});
        apb(1'b0, msd_pkg::MSD_OFF_FLAGS, 32'h0000_0000);
        check(rd, {24'h00_0000, msd_pkg::MSD_FLAGS_RESET});
        apb(1'b0, msd_pkg::MSD_OFF_REG_SEL, 32'h0000_0000);
        check(rd, {28'h000_0000, msd_pkg::MSD_SEL_RESET});
        $display("reset test done");
        // a refused opcode is kept but flagged, and the next good one clears the flag
        apb(1'b1, msd_pkg::MSD_OFF_MICRO, 32'h0000_B400);
        apb(1'b0, msd_pkg::MSD_OFF_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0002);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check({31'h0000_0000, last_err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        $display("refusal test done");
        for (int i = 0; i < 9; i++)
        begin
            run_op(tbl(i));
            $display("subtract test %0d done", i);
        end
        apb(1'b0, msd_pkg::MSD_OFF_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        complete_run();
    end
endmodule
